// ### pkg/dmb_defines.svh
`ifndef DMB_DEFINES_SVH
`define DMB_DEFINES_SVH

// clock and memory cycle timing
`define DMB_CLK_PERIOD_NS   5
`define DMB_CYCLE_NS        500
`define DMB_CYCLE_CLKS      (`DMB_CYCLE_NS / `DMB_CLK_PERIOD_NS)
// phases within one memory cycle, in clocks from cycle start; address strobe high time counted back from cycle end
`define DMB_ADDR_HOLD_CLKS  8
`define DMB_AS_HIGH_CLKS    25
`define DMB_DS_FALL_CLKS    40
`define DMB_DS_RISE_CLKS    96
// warning interval limit
`define DMB_WARN_MAX_US     23
`define DMB_WARN_MAX_CLKS   ((`DMB_WARN_MAX_US * 1000) / `DMB_CLK_PERIOD_NS)
// register map access: acknowledge delay for reads (synchronisation)
`define DMB_REG_ACK_CLKS    40
// scroll map
`define DMB_SCROLL_ROWS     26
`define DMB_CTRL_FIRST_IDX  5'h19
`define DMB_ROWS_MIN        5'h01
`define DMB_ROWS_MAX        5'h19
// register map: scroll map occupies indices 0..25, 26 holds start row,
// 27 holds row count, 28 warning low, 29 warning high, 30 status (read only)
`define DMB_REG_START_ROW   8'h1a
`define DMB_REG_ROW_COUNT   8'h1b
`define DMB_REG_WARN_LO     8'h1c
`define DMB_REG_WARN_HI     8'h1d
`define DMB_REG_STATUS      8'h1e
`define DMB_WORDS_PER_ROW   8'h28

`endif

// ### pkg/dmb_pkg.sv
package dmb_pkg;
  typedef enum logic [2:0] {
    DMB_IDLE  = 3'b000,
    DMB_WARN  = 3'b001,
    DMB_CYCLE = 3'b010,
    DMB_DONE  = 3'b011
  } dmb_state_t;
endpackage

// ### core/dmb_scroll_map.sv
`timescale 1ns/100ps
`include "dmb_defines.svh"
module dmb_scroll_map import dmb_pkg::*; #(
  parameter int ROWS = `DMB_SCROLL_ROWS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // write port from register map
  input  wire logic       wr_en,
  input  wire logic [4:0] wr_idx,
  input  wire logic [7:0] wr_data,
  // read port for register map
  input  wire logic [4:0] rd_idx,
  output logic      [7:0] rd_data,
  // lookup port for fetch engine
  input  wire logic [4:0] scan_row,
  output logic      [7:0] mem_row
);
  logic [7:0] map_q [ROWS];
  logic [7:0] map_d [ROWS];

  always_comb begin
    for (int i = 0; i < ROWS; i++) begin
      map_d[i] = map_q[i];
    end
    if (wr_en && (32'(wr_idx) < ROWS)) begin
      map_d[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < ROWS; i++) begin
      map_q[i] <= nrst ? map_d[i] : 8'h00;
    end
  end

  assign rd_data = (32'(rd_idx) < ROWS) ? map_q[rd_idx] : 8'h00;
  assign mem_row = (32'(scan_row) < ROWS) ? map_q[scan_row] : 8'h00;
endmodule // dmb_scroll_map

// ### core/dmb_bus_if.sv
`timescale 1ns/100ps
`include "dmb_defines.svh"
// Function
// - read display memory over 16-bit muxed bus, 500 ns cycle
// - address strobe starts each cycle, latching the address
// - both byte strobes always asserted together, full word fetched
// - read/write line driven high; never writes memory
// - even bytes on upper half; only even word addresses issued
// - bus request held through access period, starting warning interval before
// - warning interval programmable from 0 to 23 us
// - register map is 8-bit RAM on upper byte, strobes become inputs
// - transfer acknowledge marks register access completion
// - write-only mode takes low data byte as register address
// - link buffer gives 8-bit host access to lower memory half
// - 26-byte scroll map holds one row pointer per displayed row
// - control bits allow 1 to 25 rows at any position
// - each row fetched in one flyback into alternate buffer half
// - short host writes allowed; acknowledge may be delayed
module dmb_bus_if import dmb_pkg::*; #(
  parameter int WORDS_PER_ROW = 40
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // display timing
  input  wire logic        flyback_start,
  input  wire logic [4:0]  scan_row,
  // multiplexed address/data bus
  input  wire logic [15:0] ad_in,
  output logic      [15:0] ad_out,
  output logic      [15:0] ad_oe,
  output logic             addr_strobe_out,
  output logic             bus_request_out,
  output logic             upper_byte_strobe_out,
  output logic             lower_byte_strobe,
  output logic             rw_out,
  output logic             ctrl_oe,
  // host register map access
  input  wire logic        register_map_enable,
  input  wire logic        upper_byte_strobe_in,
  input  wire logic        rw_in,
  input  wire logic        write_only_mode,
  output logic             transfer_ack_out,
  // link-through buffer
  input  wire logic        link_buffer_enable,
  input  wire logic        send_receive,
  input  wire logic [7:0]  host_data_in,
  output logic      [7:0]  host_data_out,
  output logic             host_data_oe,
  // row buffer fill
  output logic      [15:0] fill_data,
  output logic      [5:0]  fill_col,
  output logic             fill_half,
  output logic             fill_valid,
  output logic             row_visible
);
  dmb_state_t  st_q, st_d;
  logic [12:0] warn_cnt_q, warn_cnt_d;
  logic [6:0]  cyc_cnt_q, cyc_cnt_d;
  logic [5:0]  word_q, word_d;
  logic        half_q, half_d;
  logic [15:0] data_q, data_d;
  logic        fv_q, fv_d;
  logic [7:0]  row_ptr_q, row_ptr_d;
  logic [7:0]  warn_lo_q, warn_lo_d, warn_hi_q, warn_hi_d;
  logic [4:0]  start_q, start_d, count_q, count_d;
  logic        ack_q, ack_d, busy_q, busy_d;
  logic [5:0]  ack_cnt_q, ack_cnt_d;
  logic [15:0] reg_rd_q, reg_rd_d;
  logic [7:0]  map_rd, mem_row, reg_addr;
  logic [12:0] warn_set;
  logic        reg_wr, map_active;
  logic [4:0]  rel_row;

  function automatic logic [12:0] clamp_warn(input logic [15:0] v);
    return (v > 16'(`DMB_WARN_MAX_CLKS)) ? 13'(`DMB_WARN_MAX_CLKS) : v[12:0];
  endfunction

  assign map_active = !register_map_enable && !upper_byte_strobe_in;
  // address on low half, low data byte in write-only mode
  assign reg_addr   = ad_in[7:0];
  assign reg_wr     = map_active && !rw_in && !busy_q;
  // warning programmed in clocks, clamped to 23 us
  assign warn_set   = clamp_warn({warn_hi_q, warn_lo_q});
  // rows shown from start position for count rows
  assign rel_row    = scan_row - start_q;
  assign row_visible = (scan_row >= start_q) && (rel_row < count_q);

  dmb_scroll_map u_map (
    .clk      (clk),
    .nrst     (nrst),
    .wr_en    (reg_wr && (reg_addr < 8'(`DMB_SCROLL_ROWS))),
    .wr_idx   (reg_addr[4:0]),
    .wr_data  (ad_in[15:8]),
    .rd_idx   (reg_addr[4:0]),
    .rd_data  (map_rd),
    .scan_row (scan_row),
    .mem_row  (mem_row)
  );

  always_comb begin
    st_d = st_q; warn_cnt_d = warn_cnt_q; cyc_cnt_d = cyc_cnt_q;
    word_d = word_q; half_d = half_q; data_d = data_q; fv_d = 1'b0;
    row_ptr_d = row_ptr_q;
    case (st_q)
      DMB_IDLE: begin
        // one fetch per row during flyback
        if (flyback_start && row_visible) begin
          row_ptr_d = mem_row;
          warn_cnt_d = warn_set;
          word_d = 6'h00;
          cyc_cnt_d = 7'h00;
          st_d = (warn_set == 13'h0000) ? DMB_CYCLE : DMB_WARN;
        end
      end
      // request raised ahead of bus activity
      DMB_WARN: begin
        warn_cnt_d = warn_cnt_q - 13'h0001;
        if (warn_cnt_q == 13'h0001) st_d = DMB_CYCLE;
      end
      DMB_CYCLE: begin
        cyc_cnt_d = cyc_cnt_q + 7'h01;
        if (cyc_cnt_q == 7'(`DMB_DS_RISE_CLKS - 1)) begin
          data_d = ad_in;
          fv_d = 1'b1;
        end
        if (cyc_cnt_q == 7'(`DMB_CYCLE_CLKS - 1)) begin
          cyc_cnt_d = 7'h00;
          word_d = word_q + 6'h01;
          if (32'(word_q) == WORDS_PER_ROW - 1) st_d = DMB_DONE;
        end
      end
      DMB_DONE: begin
        half_d = !half_q;
        st_d = DMB_IDLE;
      end
      default: st_d = DMB_IDLE;
    endcase
  end

  // register map and acknowledge
  always_comb begin
    warn_lo_d = warn_lo_q; warn_hi_d = warn_hi_q;
    start_d = start_q; count_d = count_q;
    ack_d = ack_q; busy_d = busy_q; ack_cnt_d = ack_cnt_q; reg_rd_d = reg_rd_q;
    if (!map_active) begin
      ack_d = 1'b0; busy_d = 1'b0; ack_cnt_d = 6'h00;
    end else if (!busy_q) begin
      busy_d = 1'b1;
      ack_cnt_d = 6'h00;
      if (!rw_in) begin
        case (reg_addr)
          `DMB_REG_WARN_LO:   warn_lo_d = ad_in[15:8];
          `DMB_REG_WARN_HI:   warn_hi_d = ad_in[15:8];
          `DMB_REG_START_ROW: start_d = (ad_in[12:8] > `DMB_CTRL_FIRST_IDX) ? 5'h00 : ad_in[12:8];
          `DMB_REG_ROW_COUNT: count_d = (ad_in[12:8] < `DMB_ROWS_MIN) ? `DMB_ROWS_MIN :
                                        (ad_in[12:8] > `DMB_ROWS_MAX) ? `DMB_ROWS_MAX : ad_in[12:8];
          default: ;
        endcase
        ack_d = 1'b1;
      end else begin
        case (reg_addr)
          `DMB_REG_WARN_LO:   reg_rd_d = {warn_lo_q, 8'h00};
          `DMB_REG_WARN_HI:   reg_rd_d = {warn_hi_q, 8'h00};
          `DMB_REG_START_ROW: reg_rd_d = {3'h0, start_q, 8'h00};
          `DMB_REG_ROW_COUNT: reg_rd_d = {3'h0, count_q, 8'h00};
          `DMB_REG_STATUS:    reg_rd_d = {5'h00, half_q, (st_q == DMB_CYCLE), (st_q != DMB_IDLE), 8'h00};
          default:            reg_rd_d = {map_rd, 8'h00};
        endcase
      end
    end else if (!ack_q) begin
      ack_cnt_d = ack_cnt_q + 6'h01;
      if (ack_cnt_q == 6'(`DMB_REG_ACK_CLKS - 1)) ack_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= DMB_IDLE; warn_cnt_q <= 13'h0000; cyc_cnt_q <= 7'h00;
      word_q <= 6'h00; half_q <= 1'b0; data_q <= 16'h0000; fv_q <= 1'b0;
      row_ptr_q <= 8'h00; warn_lo_q <= 8'h00; warn_hi_q <= 8'h00;
      start_q <= 5'h00; count_q <= `DMB_ROWS_MAX; ack_q <= 1'b0;
      busy_q <= 1'b0; ack_cnt_q <= 6'h00; reg_rd_q <= 16'h0000;
    end else begin
      st_q <= st_d; warn_cnt_q <= warn_cnt_d; cyc_cnt_q <= cyc_cnt_d;
      word_q <= word_d; half_q <= half_d; data_q <= data_d; fv_q <= fv_d;
      row_ptr_q <= row_ptr_d; warn_lo_q <= warn_lo_d; warn_hi_q <= warn_hi_d;
      start_q <= start_d; count_q <= count_d; ack_q <= ack_d;
      busy_q <= busy_d; ack_cnt_q <= ack_cnt_d; reg_rd_q <= reg_rd_d;
    end
  end

  logic in_cyc;
  assign in_cyc = (st_q == DMB_CYCLE);
  // request across warning and fetch, dropped after
  assign bus_request_out = !((st_q == DMB_WARN) || in_cyc);
  // strobe low after address setup, high again late in cycle
  assign addr_strobe_out = !(in_cyc && (cyc_cnt_q >= 7'(`DMB_ADDR_HOLD_CLKS - 4))
                                     && (cyc_cnt_q < 7'(`DMB_CYCLE_CLKS - `DMB_AS_HIGH_CLKS)));
  // both byte strobes from one term
  logic ds_low;
  assign ds_low = in_cyc && (cyc_cnt_q >= 7'(`DMB_DS_FALL_CLKS)) && (cyc_cnt_q < 7'(`DMB_DS_RISE_CLKS));
  assign upper_byte_strobe_out = !ds_low;
  assign lower_byte_strobe     = !ds_low;
  assign rw_out  = 1'b1;
  assign ctrl_oe = in_cyc;
  // word address = row base*80 + word*2, bit 0 always zero
  logic [15:0] word_addr;
  assign word_addr = (16'(row_ptr_q) * 16'(WORDS_PER_ROW) + 16'(word_q)) << 1;
  logic drive_addr;
  assign drive_addr = in_cyc && (cyc_cnt_q < 7'(`DMB_ADDR_HOLD_CLKS + 12));
  // read data driven on upper byte during register read
  // write-only hosts have no read-back path, so never drive
  logic drive_reg;
  assign drive_reg = map_active && rw_in && busy_q && !write_only_mode;
  // host to memory direction of link buffer
  logic drive_link;
  assign drive_link = !link_buffer_enable && !send_receive && !in_cyc;
  assign ad_out = drive_addr ? word_addr :
                  drive_reg  ? reg_rd_q  :
                  drive_link ? {8'h00, host_data_in} : 16'h0000;
  assign ad_oe  = drive_addr ? 16'hffff :
                  drive_reg  ? 16'hff00 :
                  drive_link ? 16'h00ff : 16'h0000;
  assign transfer_ack_out = !ack_q;
  assign host_data_out = ad_in[7:0];
  assign host_data_oe  = !link_buffer_enable && send_receive;
  assign fill_data  = data_q;
  assign fill_col   = word_q;
  assign fill_half  = half_q;
  assign fill_valid = fv_q;
endmodule // dmb_bus_if

// ### sim/dmb_bus_if_properties.sv
`timescale 1ns/100ps
module dmb_bus_if_props import dmb_pkg::*; (
  // clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // memory bus
  input wire logic [15:0] ad_out,
  input wire logic [15:0] ad_oe,
  input wire logic        addr_strobe_out,
  input wire logic        bus_request_out,
  input wire logic        upper_byte_strobe_out,
  input wire logic        lower_byte_strobe,
  input wire logic        rw_out,
  input wire logic        ctrl_oe,
  // host side
  input wire logic        register_map_enable,
  input wire logic        upper_byte_strobe_in,
  input wire logic        rw_in,
  input wire logic        transfer_ack_out
);
  logic [7:0] gap_q, gap_d;
  logic       as_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // cycles since the last strobe fall, saturating
  always_comb begin
    gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
    if (as_q && !addr_strobe_out) gap_d = 8'h00;
  end
  always_ff @(posedge clk) begin
    gap_q <= nrst ? gap_d : 8'hff;
    as_q  <= nrst ? addr_strobe_out : 1'b1;
  end
  sequence s_take(logic wr);
    !register_map_enable && $fell(upper_byte_strobe_in) && (rw_in == !wr);
  endsequence
  sequence s_late_ack;
    transfer_ack_out[*8] ##[31:34] !transfer_ack_out;
  endsequence
  property p_cycle; $fell(addr_strobe_out) |-> (gap_q == 8'h63 || gap_q == 8'hff); endproperty
  a_cycle: assert property (p_cycle) else $error("memory cycle length wrong");
  property p_addr; $fell(addr_strobe_out) |-> ad_oe == 16'hffff && !ad_out[0]; endproperty
  a_addr: assert property (p_addr) else $error("address not driven or odd");
  property p_pair; upper_byte_strobe_out == lower_byte_strobe; endproperty
  a_pair: assert property (p_pair) else $error("byte strobes differ");
  property p_ds_in_as; $fell(upper_byte_strobe_out) |-> !addr_strobe_out ##1 !upper_byte_strobe_out[*8]; endproperty
  a_ds_in_as: assert property (p_ds_in_as) else $error("data strobe outside cycle");
  property p_read; !upper_byte_strobe_out |-> rw_out && ctrl_oe; endproperty
  a_read: assert property (p_read) else $error("memory write seen");
  property p_br; (!addr_strobe_out || !upper_byte_strobe_out) |-> !bus_request_out; endproperty
  a_br: assert property (p_br) else $error("bus activity without request");
  property p_wack; s_take(1'b1) |=> !transfer_ack_out; endproperty
  a_wack: assert property (p_wack) else $error("write ack late");
  property p_rack; s_take(1'b0) |=> s_late_ack; endproperty
  a_rack: assert property (p_rack) else $error("read ack timing wrong");
  property p_float; $rose(bus_request_out) |-> ##[0:1] (ad_oe == 16'h0000 && !ctrl_oe); endproperty
  a_float: assert property (p_float) else $error("bus not released");
endmodule // dmb_bus_if_props

// ### sim/dmb_mem_model.sv
`timescale 1ns/100ps
module dmb_mem_model import dmb_pkg::*; (
  // memory bus
  input wire logic        clk,
  input wire logic [15:0] ad_out,
  input wire logic        addr_strobe_out,
  input wire logic        bus_request_out,
  input wire logic        upper_byte_strobe_out,
  input wire logic        lower_byte_strobe,
  output logic     [15:0] mem_ad
);
  logic [15:0] addr;
  initial begin
    addr = 16'h0000;
    mem_ad = 16'h0000;
  end
  // address latched at strobe fall only while the bus request is asserted
  always @(negedge addr_strobe_out) if (!bus_request_out) addr = ad_out;
  always @(posedge clk) mem_ad <= (!upper_byte_strobe_out && !lower_byte_strobe) ? ~addr : ~mem_ad;
endmodule // dmb_mem_model

// ### sim/dmb_bus_if_test.sv
`timescale 1ns/100ps
module dmb_bus_if_test import dmb_pkg::*;;
  logic clk = 1'b0, nrst = 1'b0, flyback_start = 1'b0, host_en = 1'b0, h0, h1;
  logic register_map_enable = 1'b1, upper_byte_strobe_in = 1'b1, rw_in = 1'b1, write_only_mode = 1'b0;
  logic link_buffer_enable = 1'b1, send_receive = 1'b0;
  logic [4:0] scan_row = 5'h00;
  logic [15:0] ad_h = 16'h0000, mem_ad, ad_in, ad_out, ad_oe, fill_data;
  logic astb_n, req_n, ustb_n, lstb_n, rw_o, ctrl_oe, ack_n, hoe, fh, fv, rv;
  logic [7:0] hdo, q, hdi = 8'h00;
  logic [5:0] fcol;
  int err_total = 0, checked = 0, n;
  assign ad_in = host_en ? ad_h : mem_ad;
  always #2.5 clk = ~clk;
  dmb_bus_if u_dut (.clk(clk), .nrst(nrst), .flyback_start(flyback_start), .scan_row(scan_row),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .addr_strobe_out(astb_n), .bus_request_out(req_n),
    .upper_byte_strobe_out(ustb_n), .lower_byte_strobe(lstb_n), .rw_out(rw_o), .ctrl_oe(ctrl_oe),
    .register_map_enable(register_map_enable), .upper_byte_strobe_in(upper_byte_strobe_in),
    .rw_in(rw_in), .write_only_mode(write_only_mode), .transfer_ack_out(ack_n),
    .link_buffer_enable(link_buffer_enable), .send_receive(send_receive), .host_data_in(hdi),
    .host_data_out(hdo), .host_data_oe(hoe), .fill_data(fill_data), .fill_col(fcol),
    .fill_half(fh), .fill_valid(fv), .row_visible(rv));
  dmb_mem_model u_mem (.clk(clk), .ad_out(ad_out), .addr_strobe_out(astb_n), .bus_request_out(req_n),
    .upper_byte_strobe_out(ustb_n), .lower_byte_strobe(lstb_n), .mem_ad(mem_ad));
  task end_sim;
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // host puts address low, data high; holds until ack
  task reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host_en = 1'b1;
    ad_h = {d, a};
    rw_in = ~wr;
    register_map_enable = 1'b0;
    upper_byte_strobe_in = 1'b0;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (ack_n !== 1'b0 && n < 100);
    q = ad_out[15:8];
    chk({15'h0, n < 100}, 16'h0001);
    @(negedge clk);
    upper_byte_strobe_in = 1'b1;
    register_map_enable = 1'b1;
    host_en = 1'b0;
  endtask
  task t_regs;
    for (int i = 0; i < 26; i += 5) begin
      reg_acc(1'b1, 8'(i), 8'(i + 8'h31));
      reg_acc(1'b0, 8'(i), 8'h00);
      chk({8'h00, q}, 16'(i + 8'h31));
    end
    write_only_mode = 1'b1;
    reg_acc(1'b1, 8'h03, 8'hc4);
    reg_acc(1'b0, 8'h03, 8'h00);
    chk({8'h00, q}, 16'h0000);
    write_only_mode = 1'b0;
    reg_acc(1'b0, 8'h03, 8'h00);
    chk({8'h00, q}, 16'h00c4);
  endtask
  task t_rows;
    reg_acc(1'b1, 8'h1a, 8'h02);
    reg_acc(1'b1, 8'h1b, 8'h01);
    for (int r = 1; r < 4; r++) begin
      @(negedge clk);
      scan_row = 5'(r);
      #1 chk({15'h0, rv}, {15'h0, r == 2});
    end
    reg_acc(1'b1, 8'h1a, 8'h00);
    reg_acc(1'b1, 8'h1b, 8'h19);
    for (int r = 0; r < 26; r++) begin
      @(negedge clk);
      scan_row = 5'(r);
      #1 chk({15'h0, rv}, {15'h0, r < 25});
    end
  endtask
  task t_fetch(input logic [4:0] r, input logic [7:0] ptr, output logic h);
    repeat (260) @(negedge clk);
    scan_row = r;
    flyback_start = 1'b1;
    @(negedge clk);
    flyback_start = 1'b0;
    n = 0;
    while (astb_n !== 1'b0 && n < 500) begin @(negedge clk); n++; end
    chk({15'h0, n >= 16 && n < 500}, 16'h0001);
    chk({15'h0, req_n}, 16'h0000);
    for (int w = 0; w < 40; w++) begin
      n = 0;
      do begin @(posedge clk); #1; n++; end while (fv !== 1'b1 && n < 200);
      chk(fill_data, ~(16'(ptr * 40 + w) << 1));
      chk({10'h0, fcol}, 16'(w));
    end
    h = fh;
    repeat (10) @(negedge clk);
    chk({15'h0, req_n}, 16'h0001);
    chk(ad_oe, 16'h0000);
  endtask
  task t_link;
    @(negedge clk);
    host_en = 1'b1;
    ad_h = 16'h00a7;
    hdi = 8'h5c;
    link_buffer_enable = 1'b0;
    send_receive = 1'b1;
    #1 chk({7'h0, hoe, hdo}, 16'h01a7);
    chk(ad_oe, 16'h0000);
    @(negedge clk);
    send_receive = 1'b0;
    #1 chk({15'h0, hoe}, 16'h0000);
    chk(ad_oe, 16'h00ff);
    chk({8'h00, ad_out[7:0]}, 16'h005c);
    @(negedge clk);
    link_buffer_enable = 1'b1;
    host_en = 1'b0;
    #1 chk(ad_oe, 16'h0000);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    t_regs();
    t_rows();
    reg_acc(1'b1, 8'h1c, 8'h10);
    reg_acc(1'b1, 8'h1d, 8'h00);
    t_fetch(5'd0, 8'h31, h0);
    t_fetch(5'd5, 8'h36, h1);
    chk({15'h0, h0 ^ h1}, 16'h0001);
    t_link();
    reg_acc(1'b0, 8'h1c, 8'h00);
    chk({8'h00, q}, 16'h0010);
    reg_acc(1'b0, 8'h1b, 8'h00);
    chk({8'h00, q}, 16'h0019);
    reg_acc(1'b0, 8'h1e, 8'h00);
    chk({8'h00, q}, 16'h0000);
    end_sim();
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
endmodule // dmb_bus_if_test
bind dmb_bus_if dmb_bus_if_props u_chk (.clk(clk), .nrst(nrst), .ad_out(ad_out), .ad_oe(ad_oe),
  .addr_strobe_out(addr_strobe_out), .bus_request_out(bus_request_out),
  .upper_byte_strobe_out(upper_byte_strobe_out), .lower_byte_strobe(lower_byte_strobe),
  .rw_out(rw_out), .ctrl_oe(ctrl_oe), .register_map_enable(register_map_enable),
  .upper_byte_strobe_in(upper_byte_strobe_in), .rw_in(rw_in), .transfer_ack_out(transfer_ack_out));
